//--- design/ebp_pkg.sv
// Shared constants and carrier types for the external bus and port pins
package ebp_pkg;
  // ==========================================================
  // Clocking
  // ==========================================================
  localparam int CLK_PERIOD_NS = 4;
  // One crystal period spans two clk cycles (two half phases)
  localparam int XTAL_PERIOD_NS = 8;
  localparam int HALF_NS = XTAL_PERIOD_NS / 2;
  localparam int HALF_CYCLES = (HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Crystal periods per machine cycle
  localparam int MC_XTAL_FAST = 4;
  localparam int MC_XTAL_SLOW_A = 64;
  localparam int MC_XTAL_SLOW_B = 1024;
  localparam logic [11:0] MC_HALVES_FAST = 12'(2 * MC_XTAL_FAST);
  localparam logic [11:0] MC_HALVES_SLOW_A = 12'(2 * MC_XTAL_SLOW_A);
  localparam logic [11:0] MC_HALVES_SLOW_B = 12'(2 * MC_XTAL_SLOW_B);
  // Latch strobe high time, counted in half crystal periods (1.5 periods)
  localparam logic [11:0] ALE_HIGH_HALVES = 12'h003;
  // Program strobe / data strobe window within a fast machine cycle
  localparam logic [11:0] STROBE_FIRST_HALF = 12'h004;
  localparam logic [11:0] STROBE_LAST_HALF = 12'h006;
  // Strong pull-high transition driver on time, in half periods
  localparam logic [1:0] TRANS_HALVES = 2'h2;
  // Reset values
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam int POR_CYCLES_DEFAULT = 16;
  // Port 1 alternate bit positions
  localparam int P1_TIMER_IO = 0;
  localparam int P1_TIMER_TRIG = 1;
  localparam int P1_SERIAL_RX = 2;
  localparam int P1_SERIAL_TX = 3;
  localparam int P1_INT_BASE = 4;

  typedef enum logic [1:0] {ACC_NONE, ACC_CODE, ACC_READ, ACC_WRITE} ebp_acc_t;

  // External access request from the core
  typedef struct packed {
    logic valid;
    ebp_acc_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ebp_ext_req_t;

  // Drive of one 8-bit pin group
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } ebp_port_drv_t;
endpackage

//--- design/ebp_pins.sv
// External memory bus, port 0/1 pin logic, reset and machine-cycle timing
`timescale 1ns/1ns
module ebp_pins
  import ebp_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEFAULT
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin,
  input wire logic power_management_mode,
  input wire logic slowest_rate,
  input wire logic reduced_emission,
  input wire logic latch_strobe_off_bit,
  input wire ebp_ext_req_t ext_req,
  output logic ext_ready,
  output logic ext_done,
  output logic [7:0] ext_rdata,
  input wire logic port0_wr,
  input wire logic port1_wr,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port1_read,
  input wire logic timer_two_io_out,
  input wire logic second_serial_transmit,
  output logic timer_two_io,
  output logic timer_two_capture_trigger,
  output logic second_serial_receive,
  output logic [3:0] ext_int_pending,
  input wire logic [3:0] ext_int_clear,
  output logic machine_tick,
  output logic core_reset,
  output logic address_latch_strobe,
  output logic program_store_strobe_n,
  output logic ext_read_strobe_n,
  output logic ext_write_strobe_n,
  output logic [7:0] port2_addr,
  output logic port2_addr_en,
  input wire logic [7:0] low_address_data_bus_in,
  output logic [7:0] low_address_data_bus_out,
  output logic [7:0] low_address_data_bus_oe,
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  output logic [7:0] port1_weak_pullup
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [1:0] rst_pin_sync;
  logic [7:0] p0_meta;
  logic [7:0] p0_sync;
  logic [7:0] p1_meta;
  logic [7:0] p1_sync;
  logic [7:0] p1_prev;

  // Two flops on every pin input before any logic looks at it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_pin_sync <= 2'h0;
      p0_meta <= 8'hFF;
      p0_sync <= 8'hFF;
      p1_meta <= 8'hFF;
      p1_sync <= 8'hFF;
      p1_prev <= 8'hFF;
    end
    else
    begin
      rst_pin_sync <= {rst_pin_sync[0], reset_pin};
      p0_meta <= low_address_data_bus_in;
      p0_sync <= p0_meta;
      p1_meta <= port1_in;
      p1_sync <= p1_meta;
      p1_prev <= p1_sync;
    end
  end

  // ==========================================================
  // Reset: pin level plus internal power-up stretch
  // ==========================================================
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  logic [POR_W-1:0] por_cnt;

  // Power-up reset so no external RC network is needed
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      por_cnt <= '0;
    else if (por_cnt != POR_W'(POR_CYCLES))
      por_cnt <= por_cnt + POR_W'(1);
  end

  // High pin level resets; pin pulldown lives in the pad
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      core_reset <= 1'b1;
    else
      core_reset <= rst_pin_sync[1] || (por_cnt != POR_W'(POR_CYCLES));
  end

  // ==========================================================
  // Machine cycle timing
  // ==========================================================
  logic [11:0] half_cnt;
  logic [11:0] mc_halves;
  logic [HALF_CYCLES-1:0] half_div;
  logic half_en;
  logic mc_last;

  // One clk per half crystal period at this rate; divider kept general
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      half_div <= '0;
    else
      half_div <= (half_div == HALF_CYCLES'(HALF_CYCLES - 1)) ?
        '0 : half_div + HALF_CYCLES'(1);
  end

  assign half_en = (half_div == HALF_CYCLES'(HALF_CYCLES - 1));
  assign mc_last = half_en && (half_cnt == mc_halves - 12'h001);
  assign machine_tick = mc_last;

  // Cycle length only changes on a boundary, so no cycle is cut short
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mc_halves <= MC_HALVES_FAST;
    else if (core_reset)
      mc_halves <= MC_HALVES_FAST;
    else if (mc_last)
    begin
      if (!power_management_mode)
        mc_halves <= MC_HALVES_FAST;
      else if (slowest_rate)
        mc_halves <= MC_HALVES_SLOW_B;
      else
        mc_halves <= MC_HALVES_SLOW_A;
    end
  end

  // Half-period position within the machine cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      half_cnt <= 12'h000;
    else if (core_reset)
      half_cnt <= 12'h000;
    else if (mc_last)
      half_cnt <= 12'h000;
    else if (half_en)
      half_cnt <= half_cnt + 12'h001;
  end

  // ==========================================================
  // External access sequencing
  // ==========================================================
  ebp_acc_t acc_kind;
  logic [15:0] acc_addr;
  logic [7:0] acc_wdata;
  logic acc_active;
  logic in_ale;
  logic in_strobe;

  // Requests are taken only at a cycle boundary and run the next cycle
  assign ext_ready = mc_last && !core_reset;
  assign acc_active = (acc_kind != ACC_NONE);
  assign in_ale = (half_cnt < ALE_HIGH_HALVES);
  assign in_strobe = (half_cnt >= STROBE_FIRST_HALF) &&
    (half_cnt <= STROBE_LAST_HALF);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_kind <= ACC_NONE;
      acc_addr <= 16'h0000;
      acc_wdata <= 8'h00;
    end
    else if (core_reset)
      acc_kind <= ACC_NONE;
    else if (mc_last)
    begin
      acc_kind <= ext_req.valid ? ext_req.kind : ACC_NONE;
      acc_addr <= ext_req.addr;
      acc_wdata <= ext_req.wdata;
    end
  end

  // Read data taken at cycle end from synchronised pins
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_done <= 1'b0;
      ext_rdata <= 8'h00;
    end
    else
    begin
      ext_done <= mc_last && acc_active && !core_reset;
      if (mc_last && (acc_kind == ACC_CODE || acc_kind == ACC_READ))
        ext_rdata <= p0_sync;
    end
  end

  // ==========================================================
  // Bus strobes
  // ==========================================================
  // Registered so the pins never glitch between states
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      address_latch_strobe <= 1'b1;
      program_store_strobe_n <= 1'b1;
      ext_read_strobe_n <= 1'b1;
      ext_write_strobe_n <= 1'b1;
    end
    else if (core_reset)
    begin
      address_latch_strobe <= 1'b1;
      program_store_strobe_n <= 1'b1;
      ext_read_strobe_n <= 1'b1;
      ext_write_strobe_n <= 1'b1;
    end
    else
    begin
      if (acc_active)
        address_latch_strobe <= in_ale;
      else if (latch_strobe_off_bit || reduced_emission)
        address_latch_strobe <= 1'b1;
      else
        address_latch_strobe <= in_ale;
      program_store_strobe_n <= !(acc_kind == ACC_CODE && in_strobe);
      ext_read_strobe_n <= !(acc_kind == ACC_READ && in_strobe);
      ext_write_strobe_n <= !(acc_kind == ACC_WRITE && in_strobe);
    end
  end

  // ==========================================================
  // Port 0: address/data bus or open-drain port
  // ==========================================================
  logic [7:0] p0_latch;
  ebp_port_drv_t p0_drv;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      p0_latch <= PORT_RESET;
    else if (core_reset)
      p0_latch <= PORT_RESET;
    else if (port0_wr)
      p0_latch <= port_wdata;
  end

  // Bus phase first, then general open-drain use
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      p0_drv <= '{level: 8'h00, oe: 8'h00};
    else if (core_reset)
      p0_drv <= '{level: 8'h00, oe: 8'h00};
    else if (acc_active && in_ale)
      p0_drv <= '{level: acc_addr[7:0], oe: 8'hFF};
    else if (acc_kind == ACC_WRITE)
      p0_drv <= '{level: acc_wdata, oe: 8'hFF};
    else if (acc_active)
      p0_drv <= '{level: 8'h00, oe: 8'h00};
    else
      p0_drv <= '{level: 8'h00, oe: ~p0_latch};
  end

  assign low_address_data_bus_out = p0_drv.level;
  assign low_address_data_bus_oe = p0_drv.oe;

  // ==========================================================
  // Port 2: high address byte
  // ==========================================================
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port2_addr <= 8'hFF;
      port2_addr_en <= 1'b0;
    end
    else
    begin
      port2_addr <= acc_active ? acc_addr[15:8] : 8'hFF;
      port2_addr_en <= acc_active && !core_reset;
    end
  end

  // ==========================================================
  // Port 1: quasi-bidirectional drivers
  // ==========================================================
  logic [7:0] p1_latch;
  logic [7:0] p1_eff;
  logic [7:0] p1_rise;
  logic [1:0] trans_cnt [8];
  logic [7:0] trans_on;
  ebp_port_drv_t p1_drv;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      p1_latch <= PORT_RESET;
    else if (core_reset)
      p1_latch <= PORT_RESET;
    else if (port1_wr)
      p1_latch <= port_wdata;
  end

  // Transmit and timer outputs pull low through the same driver
  always_comb
  begin
    p1_eff = p1_latch;
    p1_eff[P1_TIMER_IO] = p1_latch[P1_TIMER_IO] & timer_two_io_out;
    p1_eff[P1_SERIAL_TX] = p1_latch[P1_SERIAL_TX] &
      second_serial_transmit;
  end

  // Rising of the effective level arms the transition driver
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      p1_rise <= PORT_RESET;
    else
      p1_rise <= p1_eff;
  end

  // Strong pull-high lasts one crystal period, then weak pullup holds
  for (genvar i = 0; i < 8; i++)
  begin : g_trans
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        trans_cnt[i] <= 2'h0;
      else if (core_reset)
        trans_cnt[i] <= 2'h0;
      else if (p1_eff[i] && !p1_rise[i])
        trans_cnt[i] <= TRANS_HALVES;
      else if (half_en && trans_cnt[i] != 2'h0)
        trans_cnt[i] <= trans_cnt[i] - 2'h1;
    end
    assign trans_on[i] = (trans_cnt[i] != 2'h0);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      p1_drv <= '{level: 8'h00, oe: 8'h00};
    else
      p1_drv <= '{level: trans_on, oe: ~p1_eff | trans_on};
  end

  assign port1_out = p1_drv.level;
  assign port1_oe = p1_drv.oe;
  assign port1_weak_pullup = ~p1_drv.oe;

  // ==========================================================
  // Port 1 reads and alternate inputs
  // ==========================================================
  // Sampled once per machine cycle so a read sees a stable value
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      port1_read <= 8'hFF;
    else if (mc_last)
      port1_read <= p1_sync;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_two_io <= 1'b1;
      timer_two_capture_trigger <= 1'b1;
      second_serial_receive <= 1'b1;
    end
    else
    begin
      timer_two_io <= p1_sync[P1_TIMER_IO];
      timer_two_capture_trigger <= p1_sync[P1_TIMER_TRIG];
      second_serial_receive <= p1_sync[P1_SERIAL_RX];
    end
  end

  // ==========================================================
  // Edge interrupts on port 1 bits 4-7
  // ==========================================================
  logic [3:0] int_now;
  logic [3:0] int_was;
  logic [3:0] int_edge;

  assign int_now = p1_sync[P1_INT_BASE +: 4];
  assign int_was = p1_prev[P1_INT_BASE +: 4];
  // Even inputs rising, odd inputs falling
  assign int_edge = {int_was[3] & ~int_now[3], ~int_was[2] & int_now[2],
    int_was[1] & ~int_now[1], ~int_was[0] & int_now[0]};

  // Set beats clear so an edge in the clearing cycle survives
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ext_int_pending <= 4'h0;
    else if (core_reset)
      ext_int_pending <= 4'h0;
    else
      ext_int_pending <= (ext_int_pending & ~ext_int_clear) | int_edge;
  end

endmodule

//--- sim/ebp_mem_model.sv
// Behavioural external ROM, RAM and address latch on the multiplexed bus
`timescale 1ns/1ns
module ebp_mem_model
(
  input wire logic clk,
  input wire logic latch_en,
  input wire logic rom_en_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] hi,
  input wire logic [7:0] pin,
  output logic [7:0] drv,
  output logic [15:0] addr
);
  // ==========================================================
  // Latch and RAM
  // ==========================================================
  logic [7:0] ram [0:255];
  logic [7:0] last = 8'h00;
  // Clocked register, loaded at each edge with the strobe high: holds what stood on the bus as the strobe fell
  always @(posedge clk)
  begin
    if (latch_en)
      addr <= {hi, pin};
    if (!wr_n)
      ram[addr[7:0]] <= pin;
    last <= drv;
  end
  // Answer only while enabled; released bus toggles so no stale byte shows
  always_comb
  begin
    if (!rom_en_n)
      drv = addr[7:0] ^ addr[15:8] ^ 8'hA5;
    else if (!rd_n)
      drv = ram[addr[7:0]];
    else
      drv = ~last;
  end
endmodule

//--- sim/ebp_pins_chk.sv
// Concurrent checks on the external bus and port pin block
`timescale 1ns/1ns
module ebp_pins_chk
  import ebp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reduced_emission,
  input wire logic latch_strobe_off_bit,
  input wire logic power_management_mode,
  input wire logic slowest_rate,
  input wire logic [3:0] ext_int_clear,
  input wire logic machine_tick,
  input wire logic core_reset,
  input wire logic address_latch_strobe,
  input wire logic program_store_strobe_n,
  input wire logic ext_read_strobe_n,
  input wire logic ext_write_strobe_n,
  input wire logic port2_addr_en,
  input wire logic [7:0] low_address_data_bus_oe,
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic [7:0] port1_weak_pullup,
  input wire logic [3:0] ext_int_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || core_reset);
  // ==========================================================
  // Machine cycle length
  // ==========================================================
  logic [11:0] gap;
  logic [11:0] len;
  logic seen;
  logic quiet;
  // Length is fixed at each boundary; the first cycle after reset is skipped
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gap <= 12'h000;
      len <= 12'h000;
      seen <= 1'b0;
    end
    else if (core_reset)
    begin
      gap <= 12'h000;
      seen <= 1'b0;
    end
    else if (machine_tick)
    begin
      gap <= 12'h000;
      seen <= 1'b1;
      len <= !power_management_mode ? MC_HALVES_FAST :
        slowest_rate ? MC_HALVES_SLOW_B : MC_HALVES_SLOW_A;
    end
    else
      gap <= gap + 12'h001;
  end
  assign quiet = (latch_strobe_off_bit || reduced_emission) &&
    !port2_addr_en && !power_management_mode;
  // ==========================================================
  // Assertions
  // ==========================================================
  AST_RESET_PINS: assert property (disable iff (1'b0)
    sys_rst |-> address_latch_strobe && low_address_data_bus_oe == 8'h00
      && port1_weak_pullup == 8'hFF) else $error("reset pin state wrong");
  AST_CYCLE_LEN: assert property (
    machine_tick && seen |-> gap == len - 12'h001)
    else $error("machine cycle length wrong");
  AST_ALE_WIDTH: assert property (
    $rose(address_latch_strobe) && !latch_strobe_off_bit && !reduced_emission
      && !power_management_mode |-> ##1 address_latch_strobe
      ##1 address_latch_strobe ##1 !address_latch_strobe)
    else $error("latch strobe width wrong");
  AST_ALE_IDLE: assert property (
    quiet [*8] ##1 quiet [*8] |-> address_latch_strobe)
    else $error("latch strobe not held high");
  AST_ALE_ACCESS: assert property (
    $rose(port2_addr_en) && !power_management_mode |->
      address_latch_strobe ##3 !address_latch_strobe)
    else $error("no latch strobe on access");
  AST_PROG_PULSE: assert property (
    $fell(program_store_strobe_n) |-> !address_latch_strobe
      ##1 !program_store_strobe_n [*2] ##1 program_store_strobe_n)
    else $error("program strobe pulse wrong");
  AST_P0_TURN: assert property (
    !ext_read_strobe_n || !program_store_strobe_n |->
      low_address_data_bus_oe == 8'h00) else $error("bus not released");
  AST_WR_DRIVE: assert property (
    !ext_write_strobe_n |-> low_address_data_bus_oe == 8'hFF)
    else $error("write data not driven");
  AST_P1_TRANS: assert property (
    $rose(port1_out[7]) && port1_oe[7] |-> ##2 !port1_oe[7]
      && port1_weak_pullup[7]) else $error("transition driver wrong");
  AST_INT_HOLD: assert property (
    ext_int_pending[1] && !ext_int_clear[1] |=> ext_int_pending[1])
    else $error("pending flag lost");
endmodule
bind ebp_pins ebp_pins_chk u_ebp_pins_chk (.clk(clk), .sys_rst(sys_rst),
  .reduced_emission(reduced_emission),
  .latch_strobe_off_bit(latch_strobe_off_bit),
  .power_management_mode(power_management_mode),
  .slowest_rate(slowest_rate), .ext_int_clear(ext_int_clear),
  .machine_tick(machine_tick), .core_reset(core_reset),
  .address_latch_strobe(address_latch_strobe),
  .program_store_strobe_n(program_store_strobe_n),
  .ext_read_strobe_n(ext_read_strobe_n),
  .ext_write_strobe_n(ext_write_strobe_n), .port2_addr_en(port2_addr_en),
  .low_address_data_bus_oe(low_address_data_bus_oe),
  .port1_out(port1_out), .port1_oe(port1_oe),
  .port1_weak_pullup(port1_weak_pullup),
  .ext_int_pending(ext_int_pending));

//--- sim/testbench.sv
// Self-checking testbench for the external bus and port pin block
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("[ERR] %0t ns: got %0h want %0h", $time, (a), (b)); \
    end \
  end
module testbench;
  import ebp_pkg::*;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic clk, sys_rst, reset_pin, pwr_mode, slow, re, lso, port0_wr, port1_wr;
  logic ext_ready, ext_done, timer_two_io, timer_two_capture_trigger;
  logic second_serial_receive, machine_tick, core_reset;
  logic address_latch_strobe, program_store_strobe_n, port2_addr_en;
  logic ext_read_strobe_n, ext_write_strobe_n, tio_out, ser_tx;
  logic [3:0] ext_int_pending, ext_int_clear;
  logic [7:0] ext_rdata, port1_read, port_wdata, port2_addr, p0_out, p0_oe;
  logic [7:0] port1_out, port1_oe, port1_weak_pullup, p1_ext, mdl_drv;
  logic [15:0] mdl_addr;
  wire [7:0] p0_pin = (p0_oe & p0_out) | (~p0_oe & mdl_drv);
  wire [7:0] p1_pin = (port1_oe & port1_out) | (~port1_oe & p1_ext);
  ebp_ext_req_t req;
  int n_fail = 0;
  int check_count = 0;
  ebp_pins #(.POR_CYCLES(4)) u_ebp_pins (.clk(clk), .sys_rst(sys_rst),
    .reset_pin(reset_pin), .power_management_mode(pwr_mode),
    .slowest_rate(slow),
    .reduced_emission(re), .latch_strobe_off_bit(lso), .ext_req(req),
    .ext_ready(ext_ready), .ext_done(ext_done), .ext_rdata(ext_rdata),
    .port0_wr(port0_wr), .port1_wr(port1_wr), .port_wdata(port_wdata),
    .port1_read(port1_read), .timer_two_io_out(tio_out),
    .second_serial_transmit(ser_tx), .timer_two_io(timer_two_io),
    .timer_two_capture_trigger(timer_two_capture_trigger),
    .second_serial_receive(second_serial_receive),
    .ext_int_pending(ext_int_pending), .ext_int_clear(ext_int_clear),
    .machine_tick(machine_tick), .core_reset(core_reset),
    .address_latch_strobe(address_latch_strobe),
    .program_store_strobe_n(program_store_strobe_n),
    .ext_read_strobe_n(ext_read_strobe_n),
    .ext_write_strobe_n(ext_write_strobe_n), .port2_addr(port2_addr),
    .port2_addr_en(port2_addr_en), .low_address_data_bus_in(p0_pin),
    .low_address_data_bus_out(p0_out), .low_address_data_bus_oe(p0_oe),
    .port1_in(p1_pin), .port1_out(port1_out), .port1_oe(port1_oe),
    .port1_weak_pullup(port1_weak_pullup));
  ebp_mem_model u_ebp_mem_model (.clk(clk), .latch_en(address_latch_strobe),
    .rom_en_n(program_store_strobe_n), .rd_n(ext_read_strobe_n),
    .wr_n(ext_write_strobe_n), .hi(port2_addr), .pin(p0_pin),
    .drv(mdl_drv), .addr(mdl_addr));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task give_verdict;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait on a level, seen at the falling edge where it has settled
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge clk);
      if (s === v)
        return;
    end
    n_fail++;
    $display("[ERR] %0t ns: wait ran out", $time);
    give_verdict();
  endtask
  // Request held until the edge where ready is high, then dropped
  task automatic access(input ebp_acc_t k, input logic [15:0] a,
    input logic [7:0] d, input logic [7:0] x);
    @(posedge clk);
    req <= '{valid: 1'b1, kind: k, addr: a, wdata: d};
    wait_lvl(ext_ready, 1'b1, 40);
    @(posedge clk);
    req.valid <= 1'b0;
    wait_lvl(ext_done, 1'b1, 40);
    if (k != ACC_WRITE)
      `CHK(ext_rdata, x)
    `CHK(mdl_addr, a)
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_reset;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(address_latch_strobe, 1'b1)
    `CHK(p0_oe, 8'h00)
    @(posedge clk);
    sys_rst <= 1'b0;
    wait_lvl(core_reset, 1'b0, 40);
    `CHK(port1_weak_pullup, 8'hFF)
    `CHK(program_store_strobe_n, 1'b1)
    $display("reset test done");
  endtask
  task t_bus;
    access(ACC_CODE, 16'h12C3, 8'h00, 8'h12 ^ 8'hC3 ^ 8'hA5);
    access(ACC_WRITE, 16'h0044, 8'h3C, 8'h00);
    access(ACC_READ, 16'h0044, 8'h00, 8'h3C);
    $display("bus test done");
  endtask
  // Idle latch strobe lows over two cycles in each suppression mode
  task t_modes;
    int m;
    logic [7:0] n;
    for (m = 0; m < 3; m++)
    begin
      @(posedge clk);
      lso <= m == 1;
      re <= m == 2;
      wait_lvl(machine_tick, 1'b1, 40);
      wait_lvl(machine_tick, 1'b1, 40);
      n = 8'h00;
      repeat (16)
      begin
        @(negedge clk);
        n += {7'h00, !address_latch_strobe};
      end
      `CHK(n, m == 0 ? 8'h0A : 8'h00)
      access(ACC_CODE, 16'hBE00, 8'h00, 8'hBE ^ 8'hA5);
    end
    @(posedge clk);
    re <= 1'b0;
    $display("strobe mode test done");
  endtask
  task t_slow;
    int m;
    logic [11:0] n;
    for (m = 0; m < 3; m++)
    begin
      @(posedge clk);
      pwr_mode <= m != 2;
      slow <= m == 1;
      wait_lvl(machine_tick, 1'b1, 3000);
      wait_lvl(machine_tick, 1'b1, 3000);
      n = 12'h000;
      do
      begin
        @(negedge clk);
        n++;
      end
      while (machine_tick !== 1'b1 && n < 12'hBB8);
      `CHK(n, m == 0 ? MC_HALVES_SLOW_A : m == 1 ? MC_HALVES_SLOW_B :
        MC_HALVES_FAST)
    end
    $display("cycle length test done");
  endtask
  task t_port;
    @(posedge clk);
    p1_ext <= 8'h5A;
    {port0_wr, port1_wr, port_wdata} <= {2'h3, 8'h0F};
    @(posedge clk);
    {port0_wr, port1_wr} <= 2'h0;
    repeat (2) @(negedge clk);
    `CHK(p0_oe, 8'hF0)
    `CHK(p0_oe & p0_out, 8'h00)
    `CHK({port1_oe[7], port1_out[7]}, 2'h2)
    @(posedge clk);
    {port0_wr, port1_wr, port_wdata} <= {2'h3, 8'hFF};
    @(posedge clk);
    {port0_wr, port1_wr} <= 2'h0;
    repeat (3) @(negedge clk);
    `CHK({port1_oe[7], port1_out[7]}, 2'h3)
    repeat (2) @(negedge clk);
    `CHK(p0_oe, 8'h00)
    `CHK({port1_oe[7], port1_weak_pullup[7]}, 2'h1)
    wait_lvl(machine_tick, 1'b1, 40);
    wait_lvl(machine_tick, 1'b1, 40);
    // Read register only reloads at the tick edge itself
    @(negedge clk);
    `CHK(port1_read, 8'h5A)
    `CHK({second_serial_receive, timer_two_capture_trigger,
      timer_two_io}, 3'h2)
    @(posedge clk);
    ser_tx <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK({port1_oe[3], port1_out[3]}, 2'h2)
    @(posedge clk);
    ser_tx <= 1'b1;
    $display("port test done");
  endtask
  task t_int;
    @(posedge clk);
    ext_int_clear <= 4'hF;
    repeat (6) @(posedge clk);
    ext_int_clear <= 4'h0;
    p1_ext <= 8'hAA;
    repeat (8) @(negedge clk);
    `CHK(ext_int_pending, 4'h0)
    @(posedge clk);
    p1_ext <= 8'h55;
    repeat (8) @(negedge clk);
    `CHK(ext_int_pending, 4'hF)
    @(posedge clk);
    ext_int_clear <= 4'h5;
    @(posedge clk);
    ext_int_clear <= 4'h0;
    repeat (2) @(negedge clk);
    `CHK(ext_int_pending, 4'hA)
    $display("interrupt test done");
  endtask
  task t_rstpin;
    @(posedge clk);
    reset_pin <= 1'b1;
    wait_lvl(core_reset, 1'b1, 10);
    @(negedge clk);
    `CHK(address_latch_strobe, 1'b1)
    @(posedge clk);
    reset_pin <= 1'b0;
    wait_lvl(core_reset, 1'b0, 40);
    access(ACC_READ, 16'h0044, 8'h00, 8'h3C);
    $display("reset pin test done");
  endtask
  // ==========================================================
  // Clock and main sequence
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {sys_rst, reset_pin, pwr_mode, slow, re, lso, port0_wr, port1_wr} = 8'h00;
    {tio_out, ser_tx, port_wdata, p1_ext} = {2'h3, 8'hFF, 8'hFF};
    ext_int_clear = 4'h0;
    req = '0;
    // A clean rising reset edge before the first clock edge
    #1 sys_rst = 1'b1;
    t_reset();
    t_bus();
    t_modes();
    t_slow();
    t_port();
    t_int();
    t_rstpin();
    give_verdict();
  end
endmodule
